// ### inc/ssf_consts.vh
// Constants of the serial status flag block.
`ifndef SSF_CONSTS_VH
`define SSF_CONSTS_VH
`define SSF_ADDR_STATUS 12'h000
`define SSF_ADDR_CTRL 12'h004
`define SSF_ADDR_RXBUF 12'h008
`define SSF_ADDR_TXBUF 12'h00c
`define SSF_ADDR_IRQ_STAT 12'h010
`define SSF_ADDR_IRQ_MASK 12'h014
`define SSF_STATUS_RESET 8'h84
`define SSF_BIT_TX_EMPTY 7
`define SSF_BIT_RX_FULL 6
`define SSF_BIT_OVR 5
`define SSF_BIT_FRM 4
`define SSF_BIT_PAR 3
`define SSF_BIT_TX_END 2
`define SSF_BIT_RX_MP 1
`define SSF_BIT_TX_MP 0
`define SSF_CTRL_TXEN 0
`define SSF_CTRL_RXEN 1
`define SSF_CTRL_RX_IRQ_EN 2
`define SSF_CTRL_ODD 3
`define SSF_CTRL_SYNC 4
`define SSF_CTRL_RESET 8'h00
`define SSF_IRQ_RXFULL 0
`define SSF_IRQ_RXERR 1
`define SSF_IRQ_TXEMPTY 2
`define SSF_IRQ_W 3
`endif

// ### src/ssf_flag.v
// One CPU-clearable status flag with read-before-clear arming.
`include "ssf_consts.vh"
module ssf_flag #(
    parameter RESET_VAL = 1'b0
) (
    input wire pclk,
    input wire presetn,
    input wire init,
    input wire init_val,
    input wire set,
    input wire hw_clr,
    input wire rd_seen,
    input wire wr_zero,
    output reg flag_reg
);
    reg armed_reg;
    reg flag_next;
    always @* begin
        flag_next = flag_reg;
        if (wr_zero && armed_reg)
            flag_next = 1'b0;
        if (hw_clr)
            flag_next = 1'b0;
        if (set)
            flag_next = 1'b1;
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Reset value is per flag, so the empty flag comes up set.
            flag_reg <= RESET_VAL;
            armed_reg <= 1'b0;
        end else if (init) begin
            flag_reg <= init_val;
            armed_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            // A read arms the clear only while the flag is seen as 1.
            if (rd_seen)
                armed_reg <= flag_reg;
            else if (!flag_next)
                armed_reg <= 1'b0;
        end
    end
endmodule

// ### src/ssf_top.v
// Serial status register, flags, receive buffer and APB slave.
//
// Implementation choices: register access over APB and the register offsets.
`include "ssf_consts.vh"
module ssf_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire low_power_entry,
    input wire tx_load,
    input wire tx_last_bit,
    input wire rx_done,
    input wire [7:0] rx_shift_data,
    input wire rx_parity_en,
    input wire rx_parity_bit,
    input wire rx_stop_bit,
    input wire rx_mp_valid,
    input wire rx_mp_bit,
    output reg [7:0] tx_buffer_reg,
    output reg tx_data_valid_reg,
    output reg tx_multiproc_bit_reg,
    output reg tx_enable_reg,
    output reg rx_enable_reg,
    output reg parity_odd_select_reg,
    output reg sync_mode_reg,
    output reg rx_halt_reg,
    output reg tx_halt_reg,
    output reg rx_full_irq,
    output reg rx_error_irq,
    output reg irq
);
    ////////////////////////////////////////////////////////////////////////
    wire [4:0] flag_q;
    reg [7:0] ctrl_reg;
    reg [7:0] rx_buffer_reg;
    reg tx_end_flag_reg;
    reg rx_multiproc_bit_reg;
    reg [`SSF_IRQ_W-1:0] irq_stat_reg;
    reg [`SSF_IRQ_W-1:0] irq_mask_reg;
    reg rx_full_d_reg;
    reg rx_err_d_reg;
    reg tx_empty_d_reg;
    localparam [7:0] STATUS_INIT = `SSF_STATUS_RESET;
    wire tx_buffer_empty = flag_q[4];
    wire rx_buffer_full = flag_q[3];
    wire overrun_flag = flag_q[2];
    wire framing_flag = flag_q[1];
    wire parity_flag = flag_q[0];
    wire any_err = overrun_flag | framing_flag | parity_flag;
    wire [7:0] status_word = {tx_buffer_empty, rx_buffer_full, overrun_flag, framing_flag,
        parity_flag, tx_end_flag_reg, rx_multiproc_bit_reg, tx_multiproc_bit_reg};

    function hit;
        input [11:0] a;
        input [11:0] ref_addr;
        begin
            hit = (a == ref_addr);
        end
    endfunction

    // Writes and read side effects act only at the access edge; read data is loaded in the setup cycle; the slave answers with no wait states.
    wire acc = psel & penable;
    wire wr_acc = acc & pwrite;
    wire rd_acc = acc & ~pwrite;
    wire wr_status = wr_acc & hit(paddr, `SSF_ADDR_STATUS);
    wire rd_status = rd_acc & hit(paddr, `SSF_ADDR_STATUS);
    wire wr_ctrl = wr_acc & hit(paddr, `SSF_ADDR_CTRL);
    wire rd_rxbuf = rd_acc & hit(paddr, `SSF_ADDR_RXBUF);
    wire wr_txbuf = wr_acc & hit(paddr, `SSF_ADDR_TXBUF);
    wire wr_istat = wr_acc & hit(paddr, `SSF_ADDR_IRQ_STAT);
    wire wr_imask = wr_acc & hit(paddr, `SSF_ADDR_IRQ_MASK);
    wire mapped = hit(paddr, `SSF_ADDR_STATUS) | hit(paddr, `SSF_ADDR_CTRL) |
        hit(paddr, `SSF_ADDR_RXBUF) | hit(paddr, `SSF_ADDR_TXBUF) |
        hit(paddr, `SSF_ADDR_IRQ_STAT) | hit(paddr, `SSF_ADDR_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // low-power reinit.
    wire init = low_power_entry;
    wire txen_fall = wr_ctrl & tx_enable_reg & ~pwdata[`SSF_CTRL_TXEN];
    wire rx_ok = rx_done & rx_enable_reg & ~any_err;
    wire frm_err = ~rx_stop_bit;
    wire par_err = rx_parity_en & ((^rx_shift_data ^ rx_parity_bit) != parity_odd_select_reg);
    wire ovr_err = rx_buffer_full;
    wire clean = ~frm_err & ~par_err & ~ovr_err;

    wire [4:0] set_v;
    wire [4:0] hwclr_v;
    assign set_v[4] = txen_fall | tx_load | ~tx_enable_reg;
    assign set_v[3] = rx_ok & clean;
    assign set_v[2] = rx_ok & ovr_err;
    assign set_v[1] = rx_ok & ~ovr_err & frm_err;
    assign set_v[0] = rx_ok & ~ovr_err & par_err;
    assign hwclr_v[4] = wr_txbuf & tx_enable_reg;
    assign hwclr_v[3] = rd_rxbuf;
    // errors clear only by CPU or low-power reinit; receive enable leaves them.
    assign hwclr_v[2] = 1'b0;
    assign hwclr_v[1] = 1'b0;
    assign hwclr_v[0] = 1'b0;

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : flags
            ssf_flag #(.RESET_VAL(STATUS_INIT[g + `SSF_BIT_PAR])) u_flag (
                .pclk(pclk),
                .presetn(presetn),
                .init(init),
                .init_val(STATUS_INIT[g + `SSF_BIT_PAR]),
                .set(set_v[g]),
                .hw_clr(hwclr_v[g]),
                .rd_seen(rd_status),
                .wr_zero(wr_status & ~pwdata[g + `SSF_BIT_PAR]),
                .flag_reg(flag_q[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `SSF_CTRL_RESET;
            rx_buffer_reg <= 8'h00;
            tx_buffer_reg <= 8'h00;
            tx_data_valid_reg <= 1'b0;
            tx_end_flag_reg <= STATUS_INIT[`SSF_BIT_TX_END];
            rx_multiproc_bit_reg <= 1'b0;
            tx_multiproc_bit_reg <= 1'b0;
        end else if (init) begin
            tx_end_flag_reg <= STATUS_INIT[`SSF_BIT_TX_END];
            rx_multiproc_bit_reg <= 1'b0;
            tx_multiproc_bit_reg <= 1'b0;
            tx_data_valid_reg <= 1'b0;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= pwdata[7:0];
            // errored byte still loads; overrun keeps old; disabled leaves it.
            if (rx_ok & ~ovr_err)
                rx_buffer_reg <= rx_shift_data;
            if (rx_ok & ~ovr_err & rx_mp_valid)
                rx_multiproc_bit_reg <= rx_mp_bit;
            if (wr_txbuf & tx_enable_reg) begin
                tx_buffer_reg <= pwdata[7:0];
                tx_data_valid_reg <= 1'b1;
            end else if (tx_load | ~tx_enable_reg) begin
                tx_data_valid_reg <= 1'b0;
            end
            // only the transmit multiprocessor bit is writable.
            if (wr_status)
                tx_multiproc_bit_reg <= pwdata[`SSF_BIT_TX_MP];
            if (txen_fall | (tx_last_bit & tx_buffer_empty))
                tx_end_flag_reg <= 1'b1;
            else if (hwclr_v[4] | (wr_status & ~pwdata[`SSF_BIT_TX_EMPTY] & tx_buffer_empty))
                tx_end_flag_reg <= 1'b0;
        end
    end

    always @* begin
        tx_enable_reg = ctrl_reg[`SSF_CTRL_TXEN];
        rx_enable_reg = ctrl_reg[`SSF_CTRL_RXEN];
        parity_odd_select_reg = ctrl_reg[`SSF_CTRL_ODD];
        sync_mode_reg = ctrl_reg[`SSF_CTRL_SYNC];
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events are edges of the flags so a held flag does not refire after a clear.
    wire [`SSF_IRQ_W-1:0] ev = {tx_buffer_empty & ~tx_empty_d_reg,
        any_err & ~rx_err_d_reg, rx_buffer_full & ~rx_full_d_reg};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= {`SSF_IRQ_W{1'b0}};
            irq_mask_reg <= {`SSF_IRQ_W{1'b0}};
            rx_full_d_reg <= 1'b0;
            rx_err_d_reg <= 1'b0;
            tx_empty_d_reg <= 1'b1;
            rx_full_irq <= 1'b0;
            rx_error_irq <= 1'b0;
            irq <= 1'b0;
            rx_halt_reg <= 1'b0;
            tx_halt_reg <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            rx_full_d_reg <= rx_buffer_full;
            rx_err_d_reg <= any_err;
            tx_empty_d_reg <= tx_buffer_empty;
            if (wr_imask)
                irq_mask_reg <= pwdata[`SSF_IRQ_W-1:0];
            irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? pwdata[`SSF_IRQ_W-1:0] :
                {`SSF_IRQ_W{1'b0}})) | ev;
            irq <= |(irq_stat_reg & irq_mask_reg);
            rx_full_irq <= rx_buffer_full & ctrl_reg[`SSF_CTRL_RX_IRQ_EN];
            rx_error_irq <= any_err & ctrl_reg[`SSF_CTRL_RX_IRQ_EN];
            // receive halts while any error flag stands; transmit halts only in sync mode.
            rx_halt_reg <= any_err;
            tx_halt_reg <= any_err & sync_mode_reg;
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata <= 32'h00000000;
            if (psel & ~penable & ~pwrite) begin
                if (hit(paddr, `SSF_ADDR_STATUS))
                    prdata <= {24'h000000, status_word};
                else if (hit(paddr, `SSF_ADDR_CTRL))
                    prdata <= {24'h000000, ctrl_reg};
                else if (hit(paddr, `SSF_ADDR_RXBUF))
                    prdata <= {24'h000000, rx_buffer_reg};
                else if (hit(paddr, `SSF_ADDR_TXBUF))
                    prdata <= {24'h000000, tx_buffer_reg};
                else if (hit(paddr, `SSF_ADDR_IRQ_STAT))
                    prdata <= {29'h0, irq_stat_reg};
                else if (hit(paddr, `SSF_ADDR_IRQ_MASK))
                    prdata <= {29'h0, irq_mask_reg};
            end
        end
    end
endmodule

// ### sim/ssf_chk.sv
// Port checker of the serial status flag block.
`include "ssf_consts.vh"
module ssf_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire low_power_entry,
    input wire tx_load,
    input wire rx_done,
    input wire rx_stop_bit,
    input wire [7:0] tx_buffer_reg,
    input wire tx_data_valid_reg,
    input wire tx_enable_reg,
    input wire rx_enable_reg,
    input wire sync_mode_reg,
    input wire rx_halt_reg,
    input wire tx_halt_reg
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    ////////////////////////////////////////////////////////////////////////////////
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_only; pready |-> acc; endproperty
    a_only: assert property (p_only) else $error("ready outside access");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_init;
        low_power_entry ##1 (psel && !penable && !pwrite && paddr == `SSF_ADDR_STATUS
            && !low_power_entry) |=> prdata[7:0] == `SSF_STATUS_RESET;
    endproperty
    a_init: assert property (p_init) else $error("status not reloaded");
    property p_txw;
        acc && pwrite && paddr == `SSF_ADDR_TXBUF && tx_enable_reg && !low_power_entry
            |=> tx_data_valid_reg && tx_buffer_reg == $past(pwdata[7:0]);
    endproperty
    a_txw: assert property (p_txw) else $error("tx write not taken");
    property p_load; tx_load && !(acc && pwrite) |=> !tx_data_valid_reg; endproperty
    a_load: assert property (p_load) else $error("load kept data valid");
    property p_txoff; !tx_enable_reg |=> !tx_data_valid_reg; endproperty
    a_txoff: assert property (p_txoff) else $error("empty not forced");
    property p_frm;
        rx_done && rx_enable_reg && !rx_halt_reg && !rx_stop_bit && !low_power_entry
            |-> ##[1:2] rx_halt_reg;
    endproperty
    a_frm: assert property (p_frm) else $error("framing did not halt");
    property p_sync; rx_halt_reg && sync_mode_reg && $stable(sync_mode_reg) |-> tx_halt_reg;
    endproperty
    a_sync: assert property (p_sync) else $error("sync tx not halted");
    c_frm: cover property (rx_done && !rx_stop_bit);
    c_err: cover property (pslverr);
    c_load: cover property (tx_load);
endmodule
bind ssf_top ssf_chk ssf_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .low_power_entry, .tx_load, .rx_done, .rx_stop_bit,
    .tx_buffer_reg, .tx_data_valid_reg, .tx_enable_reg, .rx_enable_reg, .sync_mode_reg,
    .rx_halt_reg, .tx_halt_reg);

// ### sim/ssf_peer.sv
// Far-side serial peer that hands finished frames and transmit events to the block.
module ssf_peer (
    input wire pclk,
    input wire parity_odd_select_reg,
    output logic rx_done = 0,
    output logic [7:0] rx_shift_data = 0,
    output logic rx_parity_en = 0,
    output logic rx_parity_bit = 0,
    output logic rx_stop_bit = 1,
    output logic rx_mp_valid = 0,
    output logic rx_mp_bit = 0,
    output logic tx_load = 0,
    output logic tx_last_bit = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    // parity sense, first stop bit only
    task automatic frame(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        rx_shift_data <= d;
        rx_parity_en <= 1;
        rx_parity_bit <= ^d ^ parity_odd_select_reg ^ bad_par;
        rx_stop_bit <= ~bad_stop;
        rx_mp_valid <= 1;
        rx_mp_bit <= d[0];
        rx_done <= 1;
        @(posedge pclk);
        rx_done <= 0;
        rx_mp_valid <= 0;
        // The data and stop lines are stale after the frame, so show their inverse rather than hold.
        rx_shift_data <= ~d;
        rx_stop_bit <= bad_stop;
        repeat (3) @(posedge pclk);
    endtask
    task automatic load;
        tx_load <= 1;
        @(posedge pclk);
        tx_load <= 0;
        tx_last_bit <= 1;
        @(posedge pclk);
        tx_last_bit <= 0;
        repeat (2) @(posedge pclk);
    endtask
endmodule

// ### sim/ssf_top_test.sv
// Self-checking bench of the serial status flag block.
`include "ssf_consts.vh"
module ssf_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, low_power_entry = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, last_err, tx_data_valid_reg, tx_multiproc_bit_reg, tx_enable_reg;
    logic rx_enable_reg, parity_odd_select_reg, sync_mode_reg, rx_halt_reg, tx_halt_reg;
    logic rx_full_irq, rx_error_irq, irq, tx_load, tx_last_bit, rx_done, rx_parity_en;
    logic rx_parity_bit, rx_stop_bit, rx_mp_valid, rx_mp_bit;
    logic [7:0] rx_shift_data, tx_buffer_reg;
    int mismatches = 0, n_checks = 0, cyc = 0;
    ssf_top ssf_top_i (.*);
    ssf_peer ssf_peer_i (.*);
    initial forever #10 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] m,
        input logic [31:0] e);
        apb(0, a, 0);
        chk(s, e, q & m);
    endtask
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc("status", `SSF_ADDR_STATUS, 'hff, 'h84);
        apb(1, `SSF_ADDR_STATUS, 'hfb);
        rdc("status", `SSF_ADDR_STATUS, 'h07, 'h05);
        chk("tx mp bit", 1, tx_multiproc_bit_reg);
        apb(0, 12'h100, 0);
        chk("slverr", 1, last_err);
        apb(1, `SSF_ADDR_CTRL, 'h07);
        apb(1, `SSF_ADDR_TXBUF, 'h11);
        ssf_peer_i.frame(8'h22, 0, 0);
        low_power_entry <= 1;
        @(posedge pclk);
        low_power_entry <= 0;
        rdc("status", `SSF_ADDR_STATUS, 'hff, 'h84);
        $display("reset test done");
    endtask
    task automatic t_rx;
        apb(1, `SSF_ADDR_IRQ_MASK, 'h07);
        apb(1, `SSF_ADDR_IRQ_STAT, 'h07);
        ssf_peer_i.frame(8'h5a, 0, 0);
        rdc("status", `SSF_ADDR_STATUS, 'hf8, 'hc0);
        chk("full irq", 1, rx_full_irq);
        rdc("irq status", `SSF_ADDR_IRQ_STAT, 'h01, 'h01);
        chk("irq", 1, irq);
        apb(1, `SSF_ADDR_IRQ_MASK, 'h00);
        @(posedge pclk);
        chk("irq mask", 0, irq);
        apb(1, `SSF_ADDR_IRQ_STAT, 'h01);
        rdc("irq status", `SSF_ADDR_IRQ_STAT, 'h01, 'h00);
        ssf_peer_i.frame(8'h33, 0, 0);
        rdc("status", `SSF_ADDR_STATUS, 'hf8, 'he0);
        chk("error irq", 1, rx_error_irq);
        rdc("rx buffer", `SSF_ADDR_RXBUF, 'hff, 'h5a);
        apb(1, `SSF_ADDR_STATUS, 'hff);
        rdc("status", `SSF_ADDR_STATUS, 'hf8, 'ha0);
        apb(1, `SSF_ADDR_STATUS, 'hdf);
        rdc("status", `SSF_ADDR_STATUS, 'hf8, 'h80);
        rdc("rx buffer", `SSF_ADDR_RXBUF, 'hff, 'h5a);
        rdc("status", `SSF_ADDR_STATUS, 'hf8, 'h80);
        apb(1, `SSF_ADDR_CTRL, 'h03);
        ssf_peer_i.frame(8'h44, 0, 0);
        chk("full irq", 0, rx_full_irq);
        rdc("rx buffer", `SSF_ADDR_RXBUF, 'hff, 'h44);
        $display("receive test done");
    endtask
    task automatic t_err;
        apb(1, `SSF_ADDR_CTRL, 'h0b);
        ssf_peer_i.frame(8'h01, 1, 0);
        rdc("status", `SSF_ADDR_STATUS, 'hfa, 'h8a);
        rdc("rx buffer", `SSF_ADDR_RXBUF, 'hff, 'h01);
        ssf_peer_i.frame(8'h02, 0, 0);
        chk("rx halt", 1, rx_halt_reg);
        chk("error irq", 0, rx_error_irq);
        rdc("rx buffer", `SSF_ADDR_RXBUF, 'hff, 'h01);
        apb(1, `SSF_ADDR_CTRL, 'h09);
        rdc("status", `SSF_ADDR_STATUS, 'hf8, 'h88);
        apb(1, `SSF_ADDR_STATUS, 'hf7);
        rdc("status", `SSF_ADDR_STATUS, 'hf8, 'h80);
        apb(1, `SSF_ADDR_CTRL, 'h0b);
        ssf_peer_i.frame(8'h03, 0, 1);
        apb(1, `SSF_ADDR_STATUS, 'hef);
        rdc("status", `SSF_ADDR_STATUS, 'hf8, 'h90);
        apb(1, `SSF_ADDR_CTRL, 'h1b);
        @(posedge pclk);
        chk("tx halt", 1, tx_halt_reg);
        apb(1, `SSF_ADDR_STATUS, 'hef);
        rdc("status", `SSF_ADDR_STATUS, 'hf8, 'h80);
        $display("error test done");
    endtask
    task automatic t_tx;
        apb(1, `SSF_ADDR_CTRL, 'h01);
        apb(1, `SSF_ADDR_TXBUF, 'ha5);
        rdc("status", `SSF_ADDR_STATUS, 'h84, 'h00);
        chk("tx buffer", 'ha5, tx_buffer_reg);
        ssf_peer_i.load;
        rdc("status", `SSF_ADDR_STATUS, 'h84, 'h84);
        apb(1, `SSF_ADDR_STATUS, 'h7f);
        rdc("status", `SSF_ADDR_STATUS, 'h84, 'h00);
        apb(1, `SSF_ADDR_CTRL, 'h00);
        rdc("status", `SSF_ADDR_STATUS, 'h84, 'h84);
        $display("transmit test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            print_verdict;
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset;
        t_rx;
        t_err;
        t_tx;
        print_verdict;
    end
endmodule
